// ---- epv_map.svh ----
`ifndef EPV_MAP_SVH
`define EPV_MAP_SVH

`define EPV_NUM_SLOTS   48
`define EPV_NUM_W       6
`define EPV_RANK_W      3
`define EPV_NUM_IRQS    32

`define EPV_NUM_RESET   6'h01
`define EPV_NUM_NMI     6'h02
`define EPV_NUM_FAULT   6'h03
`define EPV_NUM_SVC     6'h0b
`define EPV_NUM_PSV     6'h0e
`define EPV_NUM_TICK    6'h0f
`define EPV_NUM_IRQ0    6'h10
`define EPV_NUM_NONE    6'h00

`define EPV_RANK_NMI    3'h1
`define EPV_RANK_FAULT  3'h2
`define EPV_RANK_CFG0   3'h3
`define EPV_RANK_IDLE   3'h7

`define EPV_PRIO_LSB    6
`define EPV_PRIO_RST    2'h0

`define EPV_SP_OFS      32'h0000_0000
`define EPV_RESET_OFS   32'h0000_0004
`define EPV_VECTOR_BASE_OFFSET_REGISTER_RST    32'h0000_0000
`define EPV_TABLE_OFFSET_FIELD_LSB  8

`define EPV_CFG_MASK    48'hffff_ffff_c800
`define EPV_EN_RST      48'h0000_0000_c800

`endif

// ---- epv_pkg.sv ----
package epv_pkg;

  typedef enum logic [2:0] {
    EPV_ST_RESET = 3'h0,
    EPV_ST_SP    = 3'h1,
    EPV_ST_PC    = 3'h3,
    EPV_ST_RUN   = 3'h2,
    EPV_ST_ENTRY = 3'h6
  } epv_state_e;

  typedef logic [5:0] epv_num_t;
  typedef logic [2:0] epv_rank_t;
  typedef logic [1:0] epv_level_t;

endpackage : epv_pkg

// ---- epv_arb_if.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "epv_map.svh"

interface epv_arb_if;
  logic [`EPV_NUM_SLOTS-1:0]               req;
  logic [`EPV_NUM_SLOTS*`EPV_RANK_W-1:0]   rank_flat;
  logic                                    found;
  logic [`EPV_NUM_W-1:0]                   win;
  logic [`EPV_RANK_W-1:0]                  win_rank;

  modport arb  (input req, input rank_flat,
                output found, output win, output win_rank);
  modport user (output req, output rank_flat,
                input found, input win, input win_rank);
endinterface : epv_arb_if

`default_nettype wire

// ---- epv_prio_store.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "epv_map.svh"

module epv_prio_store
  import epv_pkg::*;
(
  input  wire logic                          core_clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          we_i,
  input  wire logic [`EPV_NUM_W-1:0]         idx_i,
  input  wire logic [1:0]                    level_i,
  output logic [2*`EPV_NUM_SLOTS-1:0]        level_flat_o
);

  // one 2-bit level per slot; all slots visible at once for arbitration
  genvar g;
  generate
    for (g = 0; g < `EPV_NUM_SLOTS; g++) begin : g_ent
      logic hit;
      assign hit = we_i && (idx_i == epv_num_t'(g));
      always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
          level_flat_o[2*g +: 2] <= `EPV_PRIO_RST;
        end else if (hit) begin
          level_flat_o[2*g +: 2] <= level_i;
        end
      end
    end
  endgenerate

endmodule : epv_prio_store

`default_nettype wire

// ---- epv_arb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "epv_map.svh"

module epv_arb
  import epv_pkg::*;
(
  epv_arb_if.arb a
);

  logic                    found_c;
  logic [`EPV_NUM_W-1:0]   win_c;
  logic [`EPV_RANK_W-1:0]  rank_c;

  // ascending scan with strict compare keeps the lowest number on a tie
  always_comb begin
    found_c = 1'b0;
    win_c   = `EPV_NUM_NONE;
    rank_c  = `EPV_RANK_IDLE;
    for (int i = 0; i < `EPV_NUM_SLOTS; i++) begin
      if (a.req[i] && (!found_c ||
          a.rank_flat[i*`EPV_RANK_W +: `EPV_RANK_W] < rank_c)) begin
        found_c = 1'b1;
        win_c   = i[`EPV_NUM_W-1:0];
        rank_c  = a.rank_flat[i*`EPV_RANK_W +: `EPV_RANK_W];
      end
    end
  end

  assign a.found    = found_c;
  assign a.win      = win_c;
  assign a.win_rank = rank_c;

endmodule : epv_arb

`default_nettype wire

// ---- epv_top.sv ----
// Function
// - reset stops everything at once, abandoning any operation in flight.
// - after reset, start address comes from entry 0x4; privileged thread state.
// - nmi always enabled, fixed priority -2, below only reset, never blocked.
// - while nmi handler runs only reset may preempt it.
// - fatal error has fixed priority -1, above every configurable priority.
// - exception numbers 1,2,3,11,14,15,16+; status reports the active number.
// - fixed vectors: fatal 0xc, supervisor call 0x2c, service request 0x38.
// - peripheral interrupt n vector sits at 0x40 plus 4 times n.
// - thirty-two peripheral interrupt inputs, each with its own vector.
// - table entry 0x0 holds the initial stack pointer fetched at reset.
// - vector base is zero after reset; privileged writes may relocate it.
// - system tick raised by timer reaching zero or by software.
// - supervisor call instruction raises its exception synchronously.
// - core may retire instructions before entering an asynchronous handler.
// - each configurable exception can be disabled by privileged software.
// - smaller priority value wins; reset, nmi, fatal fixed, others configurable.
// - configurable priorities reset to zero.
// - configurable levels are 0, 64, 128, 192 only.
// - equal best priority: lowest exception number is chosen.
// - strictly higher priority arrival preempts the running handler.
// - equal priority arrival does not preempt, but stays pending.
// - each exception is inactive, pending, active, or active and pending.
// - pending exception taken only if the mask register does not block it.
`timescale 1ns/1ps
`default_nettype none
`include "epv_map.svh"

module epv_top
  import epv_pkg::*;
(
  input  wire logic                         core_clk_i,
  input  wire logic                         rstn_i,
  input  wire logic [`EPV_NUM_IRQS-1:0]     irq_i,
  input  wire logic [`EPV_NUM_IRQS-1:0]     sw_irq_pend_i,
  input  wire logic                         nmi_i,
  input  wire logic                         fault_i,
  input  wire logic                         svc_exec_i,
  input  wire logic                         pendable_service_request_set_i,
  input  wire logic                         system_tick_exception_zero_i,
  input  wire logic                         system_tick_exception_sw_i,
  input  wire logic                         priv_wr_i,
  input  wire logic [`EPV_NUM_SLOTS-1:0]    en_set_i,
  input  wire logic [`EPV_NUM_SLOTS-1:0]    en_clr_i,
  input  wire logic                         prio_wr_i,
  input  wire logic [`EPV_NUM_W-1:0]        prio_idx_i,
  input  wire logic [7:0]                   prio_val_i,
  input  wire logic                         vector_base_offset_register_wr_i,
  input  wire logic [31:0]                  vector_base_offset_register_val_i,
  input  wire logic                         mask_i,
  input  wire logic                         fetch_ack_i,
  input  wire logic                         entry_ack_i,
  input  wire logic                         exc_ret_i,
  output logic                              halt_o,
  output logic                              fetch_req_o,
  output logic                              fetch_sp_o,
  output logic [31:0]                       fetch_addr_o,
  output logic                              privileged_o,
  output logic                              thread_mode_o,
  output logic                              exc_req_o,
  output logic [`EPV_NUM_W-1:0]             exc_num_o,
  output logic [31:0]                       vec_addr_o,
  output logic [`EPV_NUM_W-1:0]             exc_num_status_o,
  output logic [`EPV_NUM_SLOTS-1:0]         pend_o,
  output logic [`EPV_NUM_SLOTS-1:0]         active_o
);

  epv_state_e                      state_r;
  epv_state_e                      state_nxt;
  logic [`EPV_NUM_SLOTS-1:0]       pend_r;
  logic [`EPV_NUM_SLOTS-1:0]       pend_nxt;
  logic [`EPV_NUM_SLOTS-1:0]       act_r;
  logic [`EPV_NUM_SLOTS-1:0]       act_nxt;
  logic [`EPV_NUM_SLOTS-1:0]       en_r;
  logic [`EPV_NUM_SLOTS-1:0]       en_nxt;
  logic [31:0]                     vector_base_offset_register_r;
  logic                            req_r;
  logic [`EPV_NUM_W-1:0]           num_r;
  logic [31:0]                     vec_r;
  logic                            fetch_req_r;
  logic                            fetch_sp_r;
  logic [31:0]                     fetch_addr_r;
  logic                            halt_r;
  logic                            priv_r;
  logic                            thread_r;
  logic [`EPV_NUM_W-1:0]           status_r;

  logic [2*`EPV_NUM_SLOTS-1:0]     level_flat;
  logic [`EPV_NUM_SLOTS*`EPV_RANK_W-1:0] rank_flat;
  logic [`EPV_NUM_SLOTS-1:0]       set_vec;
  logic [`EPV_NUM_SLOTS-1:0]       eligible;
  logic [`EPV_NUM_SLOTS-1:0]       ack_oh;
  logic [`EPV_NUM_SLOTS-1:0]       ret_oh;
  logic [`EPV_RANK_W-1:0]          exec_rank;
  logic                            take;
  logic                            entry_done;
  logic                            prio_we;
  logic [31:0]                     win_vec;
  logic [31:0]                     sp_addr;
  logic [31:0]                     pc_addr;
  logic                            prio_idx_ok;
  logic                            prio_cfg;
  logic [`EPV_NUM_SLOTS-1:0]       en_ok;
  logic [`EPV_NUM_SLOTS-1:0]       mask_ok;

  // named copies of the masks, since a literal cannot be bit-selected
  localparam logic [`EPV_NUM_SLOTS-1:0] CFG_MASK   = `EPV_CFG_MASK;
  localparam logic [`EPV_NUM_SLOTS-1:0] FIXED_MASK = ~CFG_MASK;

  epv_arb_if pend_if ();
  epv_arb_if act_if ();

  // ---------------------------------------------------------------
  // priority storage and ranking
  // ---------------------------------------------------------------
  // an index past the last slot must never reach the mask select
  assign prio_idx_ok = (prio_idx_i < epv_num_t'(`EPV_NUM_SLOTS));
  assign prio_cfg    = prio_idx_ok && CFG_MASK[prio_idx_i];
  assign prio_we     = prio_wr_i && priv_wr_i && prio_cfg;

  epv_prio_store u_store (
    .core_clk_i   (core_clk_i),
    .rstn_i       (rstn_i),
    .we_i         (prio_we),
    .idx_i        (prio_idx_i),
    .level_i      (prio_val_i[`EPV_PRIO_LSB +: 2]),
    .level_flat_o (level_flat)
  );

  // ranks: 1 nmi, 2 fatal, 3..6 configurable levels, 7 thread/none
  genvar g;
  generate
    for (g = 0; g < `EPV_NUM_SLOTS; g++) begin : g_rank
      if (g == 2) begin : g_nmi
        assign rank_flat[g*3 +: 3] = `EPV_RANK_NMI;
      end else if (g == 3) begin : g_fault
        assign rank_flat[g*3 +: 3] = `EPV_RANK_FAULT;
      end else if (CFG_MASK[g]) begin : g_cfg
        assign rank_flat[g*3 +: 3] =
          `EPV_RANK_CFG0 + {1'b0, level_flat[2*g +: 2]};
      end else begin : g_none
        assign rank_flat[g*3 +: 3] = `EPV_RANK_IDLE;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // pending sources
  // ---------------------------------------------------------------
  assign set_vec[0]     = 1'b0;
  assign set_vec[1]     = 1'b0;
  assign set_vec[2]     = nmi_i;
  assign set_vec[3]     = fault_i;
  assign set_vec[10:4]  = 7'h00;
  assign set_vec[11]    = svc_exec_i;
  assign set_vec[13:12] = 2'h0;
  assign set_vec[14]    = pendable_service_request_set_i;
  assign set_vec[15]    = system_tick_exception_zero_i | system_tick_exception_sw_i;
  assign set_vec[47:16] = irq_i | sw_irq_pend_i;

  // nmi and fatal have no enable and are never masked
  assign en_ok    = en_r | FIXED_MASK;
  assign mask_ok  = ~({`EPV_NUM_SLOTS{mask_i}} & CFG_MASK);
  assign eligible = pend_r & en_ok & mask_ok;

  assign pend_if.req       = eligible;
  assign pend_if.rank_flat = rank_flat;
  assign act_if.req        = act_r;
  assign act_if.rank_flat  = rank_flat;

  epv_arb u_pend_arb (.a(pend_if));
  epv_arb u_act_arb  (.a(act_if));

  // the running handler is the most urgent active one, since nesting
  // only ever goes to strictly better ranks
  assign exec_rank = act_if.found ? act_if.win_rank : `EPV_RANK_IDLE;

  // strict compare: equal rank never preempts; nmi at rank 1 beats all
  assign take = pend_if.found && (pend_if.win_rank < exec_rank);

  assign win_vec = vector_base_offset_register_r + {24'h00_0000, pend_if.win, 2'b00};
  assign sp_addr = vector_base_offset_register_r + `EPV_SP_OFS;
  assign pc_addr = vector_base_offset_register_r + `EPV_RESET_OFS;

  assign entry_done = (state_r == EPV_ST_ENTRY) && entry_ack_i;

  generate
    for (g = 0; g < `EPV_NUM_SLOTS; g++) begin : g_oh
      assign ack_oh[g] = entry_done && (num_r == epv_num_t'(g));
      assign ret_oh[g] = exc_ret_i && act_if.found &&
                         (act_if.win == epv_num_t'(g));
    end
  endgenerate

  // a new request in the same cycle as the entry acknowledge keeps the bit pending
  assign pend_nxt = (pend_r & ~ack_oh) | set_vec;
  assign act_nxt  = (act_r & ~ret_oh) | ack_oh;
  assign en_nxt   = priv_wr_i
                  ? ((en_r & ~(en_clr_i & `EPV_CFG_MASK))
                     | (en_set_i & `EPV_CFG_MASK))
                  : en_r;

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      EPV_ST_RESET: begin
        state_nxt = EPV_ST_SP;
      end
      EPV_ST_SP: begin
        if (fetch_ack_i) begin
          state_nxt = EPV_ST_PC;
        end
      end
      EPV_ST_PC: begin
        if (fetch_ack_i) begin
          state_nxt = EPV_ST_RUN;
        end
      end
      EPV_ST_RUN: begin
        if (take) begin
          state_nxt = EPV_ST_ENTRY;
        end
      end
      EPV_ST_ENTRY: begin
        if (entry_ack_i || !take) begin
          state_nxt = EPV_ST_RUN;
        end
      end
      default: begin
        state_nxt = EPV_ST_RESET;
      end
    endcase
  end

  // synchronous reset drops every state bit the same edge: no wind-down
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r <= EPV_ST_RESET;
      pend_r  <= '0;
      act_r   <= '0;
      en_r    <= `EPV_EN_RST;
    end else begin
      state_r <= state_nxt;
      pend_r  <= pend_nxt;
      act_r   <= act_nxt;
      en_r    <= en_nxt;
    end
  end

  // table base keeps only the aligned part of the written offset
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      vector_base_offset_register_r <= `EPV_VECTOR_BASE_OFFSET_REGISTER_RST;
    end else if (vector_base_offset_register_wr_i && priv_wr_i) begin
      vector_base_offset_register_r <= {vector_base_offset_register_val_i[31:`EPV_TABLE_OFFSET_FIELD_LSB],
                 {`EPV_TABLE_OFFSET_FIELD_LSB{1'b0}}};
    end
  end

  // boot fetches: stack pointer word, then start address word
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      halt_r       <= 1'b1;
      fetch_req_r  <= 1'b0;
      fetch_sp_r   <= 1'b0;
      fetch_addr_r <= '0;
      priv_r       <= 1'b1;
    end else begin
      halt_r       <= (state_nxt == EPV_ST_RESET) ||
                      (state_nxt == EPV_ST_SP) ||
                      (state_nxt == EPV_ST_PC);
      fetch_req_r  <= (state_nxt == EPV_ST_SP) ||
                      (state_nxt == EPV_ST_PC);
      fetch_sp_r   <= (state_nxt == EPV_ST_SP);
      fetch_addr_r <= (state_nxt == EPV_ST_SP) ? sp_addr : pc_addr;
      priv_r       <= 1'b1;
    end
  end

  // entry request; a better winner while waiting replaces the old one
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      req_r <= 1'b0;
      num_r <= `EPV_NUM_NONE;
      vec_r <= '0;
    end else if (state_nxt == EPV_ST_ENTRY) begin
      req_r <= 1'b1;
      num_r <= pend_if.win;
      vec_r <= win_vec;
    end else begin
      req_r <= 1'b0;
    end
  end

  // status follows the running handler; zero means thread state
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      status_r <= `EPV_NUM_NONE;
      thread_r <= 1'b1;
    end else begin
      status_r <= act_if.found ? act_if.win : `EPV_NUM_NONE;
      thread_r <= ~|act_nxt;
    end
  end

  assign halt_o           = halt_r;
  assign fetch_req_o      = fetch_req_r;
  assign fetch_sp_o       = fetch_sp_r;
  assign fetch_addr_o     = fetch_addr_r;
  assign privileged_o     = priv_r;
  assign thread_mode_o    = thread_r;
  assign exc_req_o        = req_r;
  assign exc_num_o        = num_r;
  assign vec_addr_o       = vec_r;
  assign exc_num_status_o = status_r;
  assign pend_o           = pend_r;
  assign active_o         = act_r;

endmodule : epv_top

`default_nettype wire

// ---- epv_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module epv_checker (
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire logic        nmi_i,
  input wire logic        mask_i,
  input wire logic        fetch_ack_i,
  input wire logic        entry_ack_i,
  input wire logic        exc_ret_i,
  input wire logic        halt_o,
  input wire logic        fetch_req_o,
  input wire logic        fetch_sp_o,
  input wire logic [31:0] fetch_addr_o,
  input wire logic        privileged_o,
  input wire logic        thread_mode_o,
  input wire logic        exc_req_o,
  input wire logic [5:0]  exc_num_o,
  input wire logic [31:0] vec_addr_o,
  input wire logic [5:0]  exc_num_status_o,
  input wire logic [47:0] pend_o,
  input wire logic [47:0] active_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_RESET_QUIET: assert property ($rose(rstn_i) |-> halt_o
    && !exc_req_o && !fetch_req_o) else $error("busy after reset");
  AST_BOOT_ADDR: assert property (fetch_req_o |-> halt_o
    && fetch_addr_o == (fetch_sp_o ? 32'h0 : 32'h4)) else $error("boot addr");
  AST_BOOT_ORDER: assert property (fetch_req_o && fetch_ack_i |=>
    fetch_req_o == $past(fetch_sp_o) && !fetch_sp_o && halt_o == fetch_req_o)
    else $error("boot order");
  AST_VEC_NUM: assert property (exc_req_o |->
    vec_addr_o[7:0] == {exc_num_o, 2'b00}) else $error("vector slot");
  AST_REQ_PENDING: assert property (exc_req_o |-> pend_o[exc_num_o])
    else $error("request not pending");
  AST_NMI_PEND: assert property (nmi_i |=> pend_o[2])
    else $error("nmi not pended");
  AST_NMI_SOLE: assert property (active_o[2] && $past(active_o[2])
    |-> !exc_req_o) else $error("nmi preempted");
  AST_MASK: assert property (mask_i [*3] |-> !exc_req_o ||
    exc_num_o inside {6'h02, 6'h03}) else $error("masked taken");
  AST_STATUS: assert property (entry_ack_i && exc_req_o |-> ##2
    exc_num_status_o == $past(exc_num_o, 2)) else $error("status");
  AST_THREAD: assert property (privileged_o &&
    thread_mode_o == (active_o == 48'h0)) else $error("thread mode");
  cover property (fetch_req_o && fetch_ack_i && !fetch_sp_o);
  cover property (entry_ack_i && exc_req_o && exc_num_o == 6'h02);
  cover property (mask_i && exc_req_o);
  cover property (exc_ret_i ##1 exc_req_o);
endmodule : epv_checker
bind epv_top epv_checker i_chk (.*);
`default_nettype wire

// ---- epv_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module epv_core_model (
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic fetch_req_i,
  input  wire logic exc_req_i,
  input  wire logic slow_i,
  output logic      fetch_ack_o,
  output logic      entry_ack_o
);
  logic [1:0] wait_r;
  initial begin
    fetch_ack_o = 1'b0;
    entry_ack_o = 1'b0;
    wait_r = 2'h0;
  end
  // a slow core retires a few instructions before it takes the entry
  always @(posedge core_clk_i) begin
    fetch_ack_o <= 1'b0;
    entry_ack_o <= 1'b0;
    if (!rstn_i || !(fetch_req_i && !fetch_ack_o || exc_req_i && !entry_ack_o))
      wait_r <= 2'h0;
    else if (wait_r < (slow_i ? 2'h3 : 2'h0))
      wait_r <= wait_r + 2'h1;
    else begin
      wait_r <= 2'h0;
      fetch_ack_o <= fetch_req_i;
      entry_ack_o <= exc_req_i & ~fetch_req_i;
    end
  end
endmodule : epv_core_model
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk_i, rstn_i, nmi_i, fault_i, svc_exec_i, pendable_service_request_set_i, slow;
  logic system_tick_exception_zero_i, system_tick_exception_sw_i, priv_wr_i, prio_wr_i, vector_base_offset_register_wr_i;
  logic mask_i, fetch_ack_i, entry_ack_i, exc_ret_i, exc_req_o, halt_o;
  logic fetch_req_o, fetch_sp_o, privileged_o, thread_mode_o;
  logic [31:0] irq_i, sw_irq_pend_i, vector_base_offset_register_val_i, fetch_addr_o, vec_addr_o;
  logic [31:0] base;
  logic [47:0] en_set_i, en_clr_i, pend_o, active_o;
  logic [5:0]  prio_idx_i, exc_num_o, exc_num_status_o, a, b;
  logic [7:0]  prio_val_i;
  logic [5:0]  fixed [5] = '{6'h02, 6'h03, 6'h0b, 6'h0e, 6'h0f};
  int          miscompares, num_checks, seed, i, k;
  epv_top i_dut (.*);
  epv_core_model i_core (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .fetch_req_i(fetch_req_o), .exc_req_i(exc_req_o), .slow_i(slow),
    .fetch_ack_o(fetch_ack_i), .entry_ack_o(entry_ack_i));
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic tmo;
    if (i >= 40) begin
      miscompares++;
      end_sim();
    end
  endtask : tmo
  task automatic src(input logic [47:0] m);
    logic [31:0] r;
    r = $random(seed);
    @(posedge core_clk_i);
    {nmi_i, fault_i, svc_exec_i, pendable_service_request_set_i} <= {m[2], m[3], m[11], m[14]};
    {system_tick_exception_zero_i, system_tick_exception_sw_i} <= {m[15] & r[0], m[15] & ~r[0]};
    irq_i <= m[47:16] & r;
    sw_irq_pend_i <= m[47:16] & ~r;
    @(posedge core_clk_i);
    {nmi_i, fault_i, svc_exec_i, pendable_service_request_set_i} <= 4'h0;
    {system_tick_exception_zero_i, system_tick_exception_sw_i, irq_i, sw_irq_pend_i} <= '0;
  endtask : src
  task automatic priv(input logic [47:0] s, input logic [47:0] c,
                      input logic [5:0] idx, input logic [7:0] v);
    @(posedge core_clk_i);
    {priv_wr_i, prio_wr_i, en_set_i, en_clr_i} <= {2'b11, s, c};
    {prio_idx_i, prio_val_i} <= {idx, v};
    @(posedge core_clk_i);
    {priv_wr_i, prio_wr_i, en_set_i, en_clr_i} <= '0;
  endtask : priv
  function automatic logic [31:0] exp_vec(input logic [5:0] num);
    case (num)
      6'h02:   exp_vec = base + 32'h8;
      6'h03:   exp_vec = base + 32'hc;
      6'h0b:   exp_vec = base + 32'h2c;
      6'h0e:   exp_vec = base + 32'h38;
      6'h0f:   exp_vec = base + 32'h3c;
      default: exp_vec = base + 32'h40 + 32'(num - 6'h10) * 32'h4;
    endcase
  endfunction : exp_vec
  task automatic take(input logic [5:0] num);
    @(negedge core_clk_i);
    for (i = 0; i < 40 && exc_req_o !== 1'b1; i++) @(negedge core_clk_i);
    tmo();
    chk({exc_num_o, vec_addr_o}, {num, exp_vec(num)});
    chk(vec_addr_o[1:0], 2'b00);
    for (i = 0; i < 40 && exc_req_o !== 1'b0; i++) @(negedge core_clk_i);
    tmo();
    repeat (2) @(negedge core_clk_i);
    chk(exc_num_status_o, num);
    chk(active_o[num], 1'b1);
  endtask : take
  task automatic ret;
    @(posedge core_clk_i);
    exc_ret_i <= 1'b1;
    @(posedge core_clk_i);
    exc_ret_i <= 1'b0;
  endtask : ret
  task automatic none;
    repeat (6) begin
      @(negedge core_clk_i);
      chk(exc_req_o, 1'b0);
    end
  endtask : none
  task automatic rst;
    @(posedge core_clk_i);
    rstn_i <= 1'b0;
    // the low level is first seen at the next edge
    repeat (2) @(negedge core_clk_i);
    chk({halt_o, exc_req_o, fetch_req_o}, 3'b100);
    repeat (9) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    base = 32'h0;
    for (i = 0; i < 40 && fetch_req_o !== 1'b1; i++) @(negedge core_clk_i);
    tmo();
    chk({fetch_sp_o, fetch_addr_o}, {1'b1, 32'h0});
    for (i = 0; i < 40 && fetch_sp_o !== 1'b0; i++) @(negedge core_clk_i);
    tmo();
    chk(fetch_addr_o, 32'h4);
    for (i = 0; i < 40 && halt_o !== 1'b0; i++) @(negedge core_clk_i);
    tmo();
    chk({privileged_o, thread_mode_o, pend_o}, {2'b11, 48'h0});
  endtask : rst
  initial begin
    {nmi_i, fault_i, svc_exec_i, pendable_service_request_set_i, system_tick_exception_zero_i} = '0;
    {system_tick_exception_sw_i, priv_wr_i, prio_wr_i, vector_base_offset_register_wr_i, mask_i} = '0;
    {exc_ret_i, slow, rstn_i, irq_i, sw_irq_pend_i, vector_base_offset_register_val_i} = '0;
    {en_set_i, en_clr_i, prio_idx_i, prio_val_i} = '0;
    seed = 99;
    rst();
    priv(48'hffff_ffff_c800, '0, '0, '0);
    for (k = 0; k < 5; k++) begin
      src(48'h1 << fixed[k]);
      take(fixed[k]);
      ret();
    end
    for (k = 0; k < 32; k++) begin
      slow <= $random(seed);
      src(48'h1 << (16 + k));
      take(6'(16 + k));
      ret();
    end
    $display("vectors done");
    a = 6'($unsigned($random(seed)) % 31) + 6'h10;
    b = 6'h2f;
    src((48'h1 << a) | (48'h1 << b));
    take(a);
    ret();
    take(b);
    ret();
    priv('0, '0, a, 8'h40 | 8'($random(seed) & 63));
    src((48'h1 << a) | (48'h1 << b));
    take(b);
    ret();
    take(a);
    src(48'h1 << b);
    take(b);
    ret();
    priv('0, '0, b, 8'h7f);
    src(48'h1 << b);
    none();
    chk(pend_o[b], 1'b1);
    src(48'h8);
    take(6'h03);
    src(48'h4);
    take(6'h02);
    src(48'h8);
    none();
    ret();
    ret();
    take(6'h03);
    ret();
    ret();
    take(b);
    ret();
    $display("priority done");
    mask_i <= 1'b1;
    src(48'h1 << a);
    none();
    src(48'h4);
    take(6'h02);
    ret();
    mask_i <= 1'b0;
    take(a);
    ret();
    priv('0, 48'h1 << a, '0, '0);
    src(48'h1 << a);
    none();
    priv(48'h1 << a, '0, '0, '0);
    take(a);
    ret();
    $display("mask done");
    @(posedge core_clk_i);
    {priv_wr_i, vector_base_offset_register_wr_i, vector_base_offset_register_val_i} <= {2'b11, 32'($random(seed))};
    @(posedge core_clk_i);
    {priv_wr_i, vector_base_offset_register_wr_i} <= 2'b00;
    base = vector_base_offset_register_val_i & 32'hffff_ff00;
    src(48'h800);
    take(6'h0b);
    src(48'h1 << a);
    rst();
    $display("relocate done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
